// file: verilog/buck_seq_pkg.sv
package buck_seq_pkg;

   // timebase
   localparam int CLK_PERIOD_NS = 5;
   localparam int OSC_PERIOD_NS = 1000;
   localparam int OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SYNC_LOSS_PERIODS = 4;
   localparam int SYNC_LOSS_CYC = SYNC_LOSS_PERIODS * OSC_CYC;
   localparam int DEAD_TIME_NS = 10;
   localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFT_STEP_US = 250;
   localparam int SOFT_STEP_CYC = SOFT_STEP_US * 1000 / CLK_PERIOD_NS;
   localparam int LBO_MASK_US = 500;
   localparam int LBO_MASK_CYC = LBO_MASK_US * 1000 / CLK_PERIOD_NS;
   localparam int PG_DELAY_US = 250;
   localparam int PG_DELAY_CYC = PG_DELAY_US * 1000 / CLK_PERIOD_NS;
   localparam int PSAVE_ENTRY_CYCLES = 32;

   // counter widths
   localparam int TIMER_W = 17;
   localparam int OSC_W = 10;
   localparam int DEAD_W = 4;
   localparam int LIGHT_W = 6;

   // current limit codes: 300 mA, 600 mA, 1200 mA, 2.4 A
   localparam logic [1:0] ILIM_300MA = 2'h0;
   localparam logic [1:0] ILIM_600MA = 2'h1;
   localparam logic [1:0] ILIM_1200MA = 2'h2;
   localparam logic [1:0] ILIM_2400MA = 2'h3;

   // register map
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam int CTRL_ENHANCED_BIT = 0;
   localparam int CTRL_FORCE_PWM_BIT = 1;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_LOCK_BIT = 8;
   localparam int STAT_PFM_BIT = 9;
   localparam int STAT_LOWBAT_BIT = 10;
   localparam int STAT_INREG_BIT = 11;
   localparam int STAT_STEP_LSB = 12;
   localparam int STAT_PREBIAS_BIT = 14;

   typedef enum logic [5:0] {
      ST_SHUTDOWN = 6'b000001,
      ST_BATT_WAIT = 6'b000010,
      ST_INPUT_UNDERVOLTAGE_LOCK = 6'b000100,
      ST_THERMAL = 6'b001000,
      ST_SOFT_START = 6'b010000,
      ST_RUN = 6'b100000
   } seq_state_t;

   typedef enum logic [4:0] {
      PH_OFF = 5'b00001,
      PH_DEAD_H = 5'b00010,
      PH_HIGH = 5'b00100,
      PH_DEAD_L = 5'b01000,
      PH_LOW = 5'b10000
   } sw_phase_t;

endpackage

// file: verilog/buck_converter_mode_sequencer.sv
// Overview of operation
// R1: enable low shuts everything down; the code keeps referenceOn high while overTemp is high
// R2: shutdown: battery flag floats, regulation held low
// R3: thermal shutdown keeps bandgap reference powered
// R4: enable starts through soft start
// R5: battery below trip drives flag low
// R6: battery flag masked first 500 us
// R7: battery detection off while disabled
// R8: enhanced: only bandgap until battery above trip
// R9: enhanced: battery above trip enables switching
// R10: regulation valid 250 us after enable
// R11: regulation released when output above 98.4%
// R12: undervoltage lock blocks both power switches
// R13: no external clock: internal 1 MHz
// R14: first sync rising edge takes over timing
// R15: four silent cycles return to internal
// R16: synchronized: forced PWM, no power save
// R17: sync low allows power save
// R18: overtemperature: FETs off, regulation floats
// R19: soft start limit 300/600/1200 mA, 2.4 A
// R20: prebias: rectifier off until ramp passes
// R21: sync high: permanent PWM, rectifier stays on
// R22: clock edge starts high side cycle
// R23: power save after 32 light cycles
// R24: never both gates, dead time between
// R25: soft start restarts after every exit
`timescale 1ns/1ps
`default_nettype none

module buck_converter_mode_sequencer
   import buck_seq_pkg::*;
#(
   parameter int SOFT_STEP_CYCLES = buck_seq_pkg::SOFT_STEP_CYC,
   parameter int LBO_MASK_CYCLES = buck_seq_pkg::LBO_MASK_CYC,
   parameter int PG_DELAY_CYCLES = buck_seq_pkg::PG_DELAY_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enable,
   input wire logic syncIn,
   input wire logic batterySenseInput,
   input wire logic inputUndervoltageLock,
   input wire logic overTemp,
   input wire logic outputGood,
   input wire logic regulationTrip,
   input wire logic currentLimitTrip,
   input wire logic lightLoad,
   input wire logic rampAbovePrebias,
   input wire logic inductorZero,
   input wire logic outputBelowNominal,
   output logic highSideGate,
   output logic lowSideGate,
   output logic [1:0] currentLimitSel,
   output logic referenceOn,
   output logic oscillatorOn,
   output logic lowBatteryFlagOut,
   output logic lowBatteryFlagOutEn,
   output logic outputInRegulation,
   output logic outputInRegulationEn
);
   import buck_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int NPIN = 12;
   logic [NPIN-1:0] pinRaw;
   logic [NPIN-1:0] pinMeta_reg;
   logic [NPIN-1:0] pinSync_reg;
   logic syncPrev_reg;
   logic enS, syncS, battS, uvloS, hotS, goodS, regTripS, limTripS;
   logic lightS, rampS, zeroS, belowS;

   assign pinRaw = {outputBelowNominal, inductorZero, rampAbovePrebias, lightLoad,
                    currentLimitTrip, regulationTrip, outputGood, overTemp,
                    inputUndervoltageLock, batterySenseInput, syncIn, enable};

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
         syncPrev_reg <= 1'b0;
      end else begin
         pinMeta_reg <= pinRaw;
         pinSync_reg <= pinMeta_reg;
         syncPrev_reg <= pinSync_reg[1];
      end
   end

   assign {belowS, zeroS, rampS, lightS, limTripS, regTripS, goodS, hotS,
           uvloS, battS, syncS, enS} = pinSync_reg;

   ////////////////////////////////////////////////////////////////////////////
   // control register
   logic [31:0] ctrl_reg;
   logic enhanced, forcePwm;

   assign enhanced = ctrl_reg[CTRL_ENHANCED_BIT];
   assign forcePwm = ctrl_reg[CTRL_FORCE_PWM_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state
   seq_state_t state_reg, state_next;
   logic [1:0] softStep_reg;
   logic [TIMER_W-1:0] stepTimer_reg;
   logic stepDone, switchActive;

   assign stepDone = (stepTimer_reg == TIMER_W'(SOFT_STEP_CYCLES - 1));
   assign switchActive = (state_reg == ST_SOFT_START) || (state_reg == ST_RUN);

   always_comb begin
      state_next = state_reg;
      if (!enS) begin
         state_next = ST_SHUTDOWN; // [R1]
      end else if (hotS) begin
         state_next = ST_THERMAL; // [R18]
      end else if (uvloS) begin
         state_next = ST_INPUT_UNDERVOLTAGE_LOCK; // [R12]
      end else if (enhanced && !battS) begin
         state_next = ST_BATT_WAIT; // [R8]
      end else begin
         case (state_reg)
            ST_SOFT_START: begin
               if (stepDone && softStep_reg == ILIM_1200MA) begin
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               state_next = ST_RUN;
            end
            default: begin
               state_next = ST_SOFT_START; // [R4] [R9] [R25]
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= ST_SHUTDOWN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         softStep_reg <= ILIM_300MA;
         stepTimer_reg <= '0;
      end else if (!switchActive) begin
         softStep_reg <= ILIM_300MA; // [R25]
         stepTimer_reg <= '0;
      end else if (state_reg == ST_SOFT_START) begin
         if (stepDone) begin
            softStep_reg <= softStep_reg + 2'h1; // [R19]
            stepTimer_reg <= '0;
         end else begin
            stepTimer_reg <= stepTimer_reg + TIMER_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock source: internal oscillator or external sync
   logic [OSC_W-1:0] oscCnt_reg;
   logic [OSC_W-1:0] lossCnt_reg;
   logic extLocked_reg;
   logic syncEdge, oscWrap, cycleTick;

   assign syncEdge = syncS && !syncPrev_reg;
   assign oscWrap = (oscCnt_reg == OSC_W'(OSC_CYC - 1));
   assign cycleTick = extLocked_reg ? syncEdge : oscWrap; // [R13] [R14]

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         oscCnt_reg <= '0;
      end else if (state_reg == ST_SHUTDOWN || syncEdge || oscWrap) begin
         oscCnt_reg <= '0;
      end else begin
         oscCnt_reg <= oscCnt_reg + OSC_W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         extLocked_reg <= 1'b0;
         lossCnt_reg <= '0;
      end else if (syncEdge) begin
         extLocked_reg <= 1'b1; // [R14]
         lossCnt_reg <= '0;
      end else if (extLocked_reg) begin
         if (lossCnt_reg == OSC_W'(SYNC_LOSS_CYC - 1)) begin
            extLocked_reg <= 1'b0; // [R15]
            lossCnt_reg <= '0;
         end else begin
            lossCnt_reg <= lossCnt_reg + OSC_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode selection: forced PWM or power save
   logic [LIGHT_W-1:0] lightCnt_reg;
   logic pfmMode_reg;
   logic psAllowed;

   // sync high or locked keeps PWM; sync low permits power save
   assign psAllowed = !extLocked_reg && !syncS && !forcePwm; // [R16] [R17] [R21]

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lightCnt_reg <= '0;
      end else if (!lightS || !psAllowed || !switchActive) begin
         lightCnt_reg <= '0;
      end else if (cycleTick && lightCnt_reg != LIGHT_W'(PSAVE_ENTRY_CYCLES)) begin
         lightCnt_reg <= lightCnt_reg + LIGHT_W'(1); // [R23]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pfmMode_reg <= 1'b0;
      end else begin
         pfmMode_reg <= psAllowed && (lightCnt_reg == LIGHT_W'(PSAVE_ENTRY_CYCLES)); // [R23]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-cycle switch timing
   sw_phase_t phase_reg;
   logic [DEAD_W-1:0] deadCnt_reg;
   logic prebiasDone_reg;
   logic deadDone;

   assign deadDone = (deadCnt_reg == DEAD_W'(DEAD_CYC - 1));

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prebiasDone_reg <= 1'b0;
      end else if (!switchActive) begin
         prebiasDone_reg <= 1'b0;
      end else if (rampS) begin
         prebiasDone_reg <= 1'b1; // [R20]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phase_reg <= PH_OFF;
         deadCnt_reg <= '0;
         highSideGate <= 1'b0;
         lowSideGate <= 1'b0;
      end else if (!switchActive) begin
         phase_reg <= PH_OFF; // [R1] [R12] [R18]
         deadCnt_reg <= '0;
         highSideGate <= 1'b0;
         lowSideGate <= 1'b0;
      end else begin
         case (phase_reg)
            PH_OFF: begin
               if (pfmMode_reg ? belowS : cycleTick) begin
                  phase_reg <= PH_DEAD_H; // [R22]
                  deadCnt_reg <= '0;
               end
            end
            PH_DEAD_H: begin
               if (deadDone) begin
                  highSideGate <= 1'b1; // [R22] [R24]
                  phase_reg <= PH_HIGH;
               end else begin
                  deadCnt_reg <= deadCnt_reg + DEAD_W'(1);
               end
            end
            PH_HIGH: begin
               // no trip before the next edge keeps the switch on: 100% duty
               if (regTripS || limTripS) begin
                  highSideGate <= 1'b0; // [R22]
                  phase_reg <= PH_DEAD_L;
                  deadCnt_reg <= '0;
               end
            end
            PH_DEAD_L: begin
               if (!pfmMode_reg && cycleTick) begin
                  phase_reg <= PH_DEAD_H;
                  deadCnt_reg <= '0;
               end else if (deadDone) begin
                  lowSideGate <= prebiasDone_reg; // [R20] [R24]
                  phase_reg <= prebiasDone_reg ? PH_LOW : PH_OFF;
               end else begin
                  deadCnt_reg <= deadCnt_reg + DEAD_W'(1);
               end
            end
            PH_LOW: begin
               if (pfmMode_reg) begin
                  if (zeroS) begin
                     lowSideGate <= 1'b0;
                     phase_reg <= PH_OFF;
                  end
               end else if (cycleTick) begin
                  lowSideGate <= 1'b0; // [R21] [R22] [R24]
                  phase_reg <= PH_DEAD_H;
                  deadCnt_reg <= '0;
               end
            end
            default: begin
               phase_reg <= PH_OFF;
               highSideGate <= 1'b0;
               lowSideGate <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // analog enables and current limit
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         referenceOn <= 1'b0;
         oscillatorOn <= 1'b0;
         currentLimitSel <= ILIM_300MA;
      end else begin
         referenceOn <= enS || hotS; // [R1] [R3] [R8]
         oscillatorOn <= switchActive && !extLocked_reg; // [R1] [R13]
         currentLimitSel <= (state_reg == ST_RUN) ? ILIM_2400MA : softStep_reg; // [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // low-battery flag and output-in-regulation
   logic [TIMER_W-1:0] lboTimer_reg;
   logic [TIMER_W-1:0] pgTimer_reg;
   logic lboValid, pgValid;

   assign lboValid = (lboTimer_reg == TIMER_W'(LBO_MASK_CYCLES));
   assign pgValid = (pgTimer_reg == TIMER_W'(PG_DELAY_CYCLES));

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lboTimer_reg <= '0;
         pgTimer_reg <= '0;
      end else begin
         if (!enS) begin
            lboTimer_reg <= '0;
         end else if (!lboValid) begin
            lboTimer_reg <= lboTimer_reg + TIMER_W'(1); // [R6]
         end
         if (!enS || uvloS) begin
            pgTimer_reg <= '0;
         end else if (!pgValid) begin
            pgTimer_reg <= pgTimer_reg + TIMER_W'(1); // [R10]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lowBatteryFlagOut <= 1'b0;
         lowBatteryFlagOutEn <= 1'b0;
         outputInRegulation <= 1'b0;
         outputInRegulationEn <= 1'b1;
      end else begin
         lowBatteryFlagOut <= 1'b0;
         outputInRegulation <= 1'b0;
         lowBatteryFlagOutEn <= enS && lboValid && !battS; // [R2] [R5] [R6] [R7]
         if (!enS) begin
            outputInRegulationEn <= 1'b1; // [R2] [R10]
         end else if (state_reg == ST_THERMAL) begin
            outputInRegulationEn <= 1'b0; // [R18]
         end else if (!pgValid) begin
            outputInRegulationEn <= 1'b1; // [R10]
         end else begin
            outputInRegulationEn <= !goodS; // [R11]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave
   logic [31:0] statusWord;
   logic [31:0] readMux;
   logic mapped, setup, accessDone;

   assign setup = psel && !penable;
   assign accessDone = psel && penable && pready;
   assign mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR);

   always_comb begin
      statusWord = 32'h00000000;
      statusWord[STAT_STATE_LSB +: 6] = state_reg;
      statusWord[STAT_LOCK_BIT] = extLocked_reg;
      statusWord[STAT_PFM_BIT] = pfmMode_reg;
      statusWord[STAT_LOWBAT_BIT] = lowBatteryFlagOutEn;
      statusWord[STAT_INREG_BIT] = !outputInRegulationEn;
      statusWord[STAT_STEP_LSB +: 2] = currentLimitSel;
      statusWord[STAT_PREBIAS_BIT] = prebiasDone_reg;
   end

   always_comb begin
      if (paddr == CTRL_ADDR) begin
         readMux = ctrl_reg;
      end else if (paddr == STATUS_ADDR) begin
         readMux = statusWord;
      end else begin
         readMux = 32'h00000000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         prdata <= (setup && !pwrite) ? readMux : 32'h00000000;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_reg <= CTRL_RESET;
      end else if (accessDone && pwrite && paddr == CTRL_ADDR) begin
         ctrl_reg <= {30'h0, pwdata[CTRL_FORCE_PWM_BIT], pwdata[CTRL_ENHANCED_BIT]};
      end
   end

endmodule

`default_nettype wire

// file: tb/buck_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module buck_seq_sva
   import buck_seq_pkg::*;
#(
   parameter int SOFT_STEP_CYCLES = 20,
   parameter int LBO_MASK_CYCLES = 40
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic syncIn,
   input wire logic batterySenseInput,
   input wire logic inputUndervoltageLock,
   input wire logic overTemp,
   input wire logic highSideGate,
   input wire logic lowSideGate,
   input wire logic [1:0] currentLimitSel,
   input wire logic referenceOn,
   input wire logic oscillatorOn,
   input wire logic lowBatteryFlagOut,
   input wire logic lowBatteryFlagOutEn,
   input wire logic outputInRegulationEn
);
   int enCnt;
   int stepCnt;
   logic [1:0] prevSel;
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // cycles since enable went high
   always_ff @(posedge ref_clk) begin
      enCnt <= (reset || !enable) ? 0 : enCnt + 1;
   end
   // cycles the current limit code has held
   always_ff @(posedge ref_clk) begin
      stepCnt <= (reset || currentLimitSel != prevSel) ? 1 : stepCnt + 1;
      prevSel <= currentLimitSel;
   end
   ////////////////////////////////////////////////////////////////
   property p_excl;
      !(highSideGate && lowSideGate);
   endproperty
   a_excl: assert property (p_excl) else $error("both gates on");
   property p_dead;
      $fell(highSideGate) |-> !lowSideGate [*2];
   endproperty
   a_dead: assert property (p_dead) else $error("no dead time");
   property p_off;
      !enable [*6] |-> !highSideGate && !lowSideGate && !oscillatorOn;
   endproperty
   a_off: assert property (p_off) else $error("active while disabled");
   property p_offFlags;
      !enable [*6] |-> outputInRegulationEn && !lowBatteryFlagOutEn;
   endproperty
   a_offFlags: assert property (p_offFlags) else $error("flags while disabled");
   property p_input_undervoltage_lock;
      inputUndervoltageLock [*6] |-> !highSideGate && !lowSideGate;
   endproperty
   a_input_undervoltage_lock: assert property (p_input_undervoltage_lock) else $error("switching in lockout");
   property p_thermal;
      overTemp [*6] |-> referenceOn && !highSideGate && !lowSideGate;
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal state wrong");
   property p_lbo;
      batterySenseInput [*5] |-> !lowBatteryFlagOutEn && !lowBatteryFlagOut;
   endproperty
   a_lbo: assert property (p_lbo) else $error("flag with battery good");
   property p_lboMask;
      $rose(lowBatteryFlagOutEn) |-> enCnt >= LBO_MASK_CYCLES;
   endproperty
   a_lboMask: assert property (p_lboMask) else $error("flag inside mask");
   property p_step;
      (currentLimitSel != prevSel && currentLimitSel != ILIM_300MA) |->
         stepCnt >= SOFT_STEP_CYCLES - 1 && currentLimitSel == prevSel + 2'h1;
   endproperty
   a_step: assert property (p_step) else $error("soft start step wrong");
   property p_lock;
      (oscillatorOn && $rose(syncIn)) ##1 syncIn [*3] |-> ##[1:4] !oscillatorOn;
   endproperty
   a_lock: assert property (p_lock) else $error("no sync takeover");
   c_full: cover property (currentLimitSel == ILIM_2400MA);
   c_rect: cover property ($rose(lowSideGate));
   c_lbo: cover property ($rose(lowBatteryFlagOutEn));
endmodule
bind buck_converter_mode_sequencer buck_seq_sva #(
   .SOFT_STEP_CYCLES(SOFT_STEP_CYCLES),
   .LBO_MASK_CYCLES(LBO_MASK_CYCLES)
) chk (.ref_clk, .reset, .enable, .syncIn, .batterySenseInput, .inputUndervoltageLock,
   .overTemp, .highSideGate, .lowSideGate, .currentLimitSel, .referenceOn, .oscillatorOn,
   .lowBatteryFlagOut, .lowBatteryFlagOutEn, .outputInRegulationEn);
`default_nettype wire

// file: tb/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
   input wire logic ref_clk,
   input wire logic slow,
   input wire logic highSideGate,
   input wire logic lowSideGate,
   output logic regulationTrip,
   output logic currentLimitTrip,
   output logic inductorZero
);
   int hiCnt = 0;
   int loCnt = 0;
   initial begin
      regulationTrip = 1'b0;
      currentLimitTrip = 1'b0;
      inductorZero = 1'b0;
   end
   // slow ramps end on the limit comparator instead of regulation
   always @(posedge ref_clk) begin
      hiCnt <= highSideGate ? hiCnt + 1 : 0;
      loCnt <= lowSideGate ? loCnt + 1 : 0;
      regulationTrip <= highSideGate && !slow && hiCnt >= 6;
      currentLimitTrip <= highSideGate && slow && hiCnt >= 40;
      inductorZero <= lowSideGate && loCnt >= 12;
   end
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import buck_seq_pkg::*;
   logic ref_clk, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, seed = 32'h50F31B6F;
   logic enable = 1'b0, syncIn = 1'b0, batterySenseInput = 1'b0, overTemp = 1'b0;
   logic inputUndervoltageLock = 1'b0, outputGood = 1'b1, lightLoad = 1'b0;
   logic rampAbovePrebias = 1'b0, outputBelowNominal = 1'b0, slow = 1'b0;
   logic syncRun = 1'b0, syncLvl = 1'b0, hsPrev = 1'b0;
   logic pready, pslverr, highSideGate, lowSideGate, referenceOn, oscillatorOn;
   logic regulationTrip, currentLimitTrip, inductorZero, lowBatteryFlagOut;
   logic lowBatteryFlagOutEn, outputInRegulation, outputInRegulationEn;
   logic [1:0] currentLimitSel;
   logic [64:0] expQ[$];
   logic [64:0] e;
   int n_fail = 0, n_compared = 0, cycles = 0, lsBad = 0, t0, t1;
   buck_converter_mode_sequencer #(.SOFT_STEP_CYCLES(20), .LBO_MASK_CYCLES(40),
      .PG_DELAY_CYCLES(30)) uut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .enable, .syncIn, .batterySenseInput,
      .inputUndervoltageLock, .overTemp, .outputGood, .regulationTrip, .currentLimitTrip,
      .lightLoad, .rampAbovePrebias, .inductorZero, .outputBelowNominal, .highSideGate,
      .lowSideGate, .currentLimitSel, .referenceOn, .oscillatorOn, .lowBatteryFlagOut,
      .lowBatteryFlagOutEn, .outputInRegulation, .outputInRegulationEn);
   power_stage_model stage (.ref_clk, .slow, .highSideGate, .lowSideGate,
      .regulationTrip, .currentLimitTrip, .inductorZero);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic report_and_stop();
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic waitRise(output int t);
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (!(highSideGate === 1'b1 && hsPrev === 1'b0) && k < 3000);
      if (k >= 3000) n_fail++;
      t = cycles;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
         input logic [31:0] x, input logic [31:0] m);
      int k;
      k = 0;
      expQ.push_back({x, m, a > STATUS_ADDR});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) n_fail++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      hsPrev <= highSideGate;
      syncIn <= syncRun ? (cycles % 180 < 60) : syncLvl;
      if (!rampAbovePrebias && lowSideGate === 1'b1) lsBad <= lsBad + 1;
      if (cycles == 30000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // answers are compared against the oldest note
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         e = expQ.pop_front();
         n_compared++;
         if ((prdata & e[32:1]) !== e[64:33] || pslverr !== e[0]) begin
            n_fail++;
            $display("BAD %0t apb data %h err %b", $time, prdata, pslverr);
         end
      end
   end
   initial begin
      cyc(12);
      reset <= 1'b0;
      @(posedge ref_clk);
      seed = xs(seed);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h1, 32'h3FFF);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 32'hFFFFFFFF);
      apb(1'b1, CTRL_ADDR, seed, 32'h0, 32'h0);
      apb(1'b0, CTRL_ADDR, 32'h0, seed & 32'h3, 32'hFFFFFFFF);
      apb(1'b1, CTRL_ADDR, CTRL_RESET, 32'h0, 32'h0);
      enable <= 1'b1;
      cyc(14);
      chk(currentLimitSel, ILIM_300MA);
      cyc(6);
      chk(outputInRegulationEn, 1'b1);
      cyc(10);
      chk(lowBatteryFlagOutEn, 1'b0);
      cyc(4);
      chk(currentLimitSel, ILIM_600MA);
      cyc(16);
      chk(outputInRegulationEn, 1'b0);
      cyc(4);
      chk(currentLimitSel, ILIM_1200MA);
      chk(lowBatteryFlagOutEn, 1'b1);
      cyc(26);
      chk(currentLimitSel, ILIM_2400MA);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h3C20, 32'h7FFF);
      batterySenseInput <= 1'b1;
      cyc(400);
      chk(lsBad, 0);
      rampAbovePrebias <= 1'b1;
      waitRise(t0);
      waitRise(t1);
      chk(t1 - t0, OSC_CYC);
      slow <= 1'b1;
      repeat (2) waitRise(t0);
      waitRise(t1);
      chk(t1 - t0, OSC_CYC);
      slow <= 1'b0;
      syncRun <= 1'b1;
      repeat (3) waitRise(t0);
      waitRise(t1);
      chk(t1 - t0, 180);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h100, 32'h100);
      syncRun <= 1'b0;
      cyc(300);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h100, 32'h100);
      cyc(800);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h0, 32'h100);
      repeat (2) waitRise(t0);
      waitRise(t1);
      chk(t1 - t0, OSC_CYC);
      lightLoad <= 1'b1;
      outputBelowNominal <= 1'b1;
      cyc(4000);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h0, 32'h200);
      cyc(3500);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h200, 32'h200);
      syncRun <= 1'b1;
      cyc(400);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h100, 32'h300);
      syncRun <= 1'b0;
      syncLvl <= 1'b1;
      cyc(1000);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h0, 32'h200);
      waitRise(t0);
      cyc(60);
      chk(lowSideGate, 1'b1);
      enable <= 1'b0;
      batterySenseInput <= 1'b0;
      cyc(8);
      chk({oscillatorOn, referenceOn, lowBatteryFlagOutEn, outputInRegulation,
         lowBatteryFlagOut}, 5'h0);
      chk(outputInRegulationEn, 1'b1);
      overTemp <= 1'b1;
      cyc(8);
      chk(referenceOn, 1'b1);
      enable <= 1'b1;
      cyc(8);
      chk(outputInRegulationEn, 1'b0);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h8, 32'h3F);
      overTemp <= 1'b0;
      cyc(8);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h10, 32'h3F);
      cyc(80);
      inputUndervoltageLock <= 1'b1;
      cyc(8);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h4, 32'h3F);
      inputUndervoltageLock <= 1'b0;
      cyc(8);
      chk(currentLimitSel, ILIM_300MA);
      enable <= 1'b0;
      apb(1'b1, CTRL_ADDR, 32'h1, 32'h0, 32'h0);
      enable <= 1'b1;
      cyc(10);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h2, 32'h3F);
      chk({referenceOn, highSideGate}, 2'h2);
      batterySenseInput <= 1'b1;
      cyc(8);
      apb(1'b0, STATUS_ADDR, 32'h0, 32'h10, 32'h3F);
      report_and_stop();
   end
endmodule
`default_nettype wire
